// >>> src/sensor_status_pkg.sv
// Constants and carrier types for the sensor device status/control bank.
// Assumes a single 200 MHz clock and a bus decoder that hands over
// already-decoded register accesses one cycle at a time.
package sensor_status_pkg;

    // ==============================================================
    // Register offsets (6-bit bus register address)
    // ==============================================================
    localparam logic [5:0] ADDR_DEV_NUM = 6'h00;
    localparam logic [5:0] ADDR_CAPS = 6'h03;
    localparam logic [5:0] ADDR_STATUS = 6'h04;
    localparam logic [5:0] ADDR_CONTROL = 6'h05;
    localparam logic [5:0] ADDR_FUNC_BASE = 6'h08;
    localparam logic [5:0] ADDR_READOUT = 6'h09;

    // ==============================================================
    // Field positions
    // ==============================================================
    localparam int ST_EVT_BIT = 0;
    localparam int ST_ERR_BIT = 4;
    localparam int ST_NACK_BIT = 7;
    localparam int CT_RESET_BIT = 0;
    localparam int CT_SHUT_BIT = 1;
    localparam int CT_LOWP_BIT = 2;
    localparam int CT_EN_BIT = 4;

    // ==============================================================
    // Reset values, masks and fixed codes
    // ==============================================================
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h0017;
    localparam logic [15:0] BCAST_WMASK = 16'h0003;
    localparam logic [2:0] DEVNUM_PIN_LOW = 3'h1;
    localparam logic [2:0] DEVNUM_PIN_HIGH = 3'h7;
    localparam logic [3:0] FUNC_TYPE_TEMP = 4'h1;
    localparam int LOWP_SLOWDOWN = 4;

    // ==============================================================
    // Timing
    // ==============================================================
    localparam int CLK_PERIOD_NS = 5;
    localparam int RST_OP_TIME_NS = 20;
    localparam int RST_OP_CYCLES =
        (RST_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==============================================================
    // Carrier types
    // ==============================================================
    typedef struct packed {
        logic wr;
        logic rd;
        logic bcast;
        logic [5:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic result_stored;
        logic error;
        logic nack;
    } func_evt_t;

endpackage

// >>> src/sensor_device_status_control.sv
// Device status and control register bank of a single-wire sensor slave.
// Assumes the bus bit decoder delivers one-cycle register requests on
// sys_clk and that the temperature function reports events as pulses.
//
// How it works
// - Status and control registers return to zero on every device reset.
// - Status bit 0 sets on function event; cleared by reset or handling.
// - Status bit 4 sets on function error; cleared by reset or handling.
// - Status bit 7 sets on any sent or received bus no-acknowledge.
// - Status bit 7 also clears as a side effect of reading status.
// - Status bits 3..1 and 6..5 always read zero.
// - Broadcast writes reach the control register, but only bits 1..0.
// - Control bit 0 starts a device reset and clears itself when done.
// - Control bit 1 set halts all functions in shutdown mode.
// - Control bit 2 set slows functions fourfold in low-power mode.
// - Control bit 3 and bits 15..5 always read zero.
// - Control bit 4 enables the temperature function; disabled after reset.
// - Function registers stay accessible while the function is disabled.
// - Temperature function reports type code 0001 in its capability word.
// - Device reset aborts operations, restarts and loads all defaults.
// - Device number is 001 with select pin low, 111 with it high.
// - Reading the readout register clears function event and error flags.
// - A result arriving before the last is read sets the error flag.
`timescale 1ns/100ps

module sensor_device_status_control #(
    parameter int SCAN_DIV = 1000
) (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic addr_select_pin, // address-select pin, asynchronous
    input wire sensor_status_pkg::reg_req_t reg_req, // register request
    input wire sensor_status_pkg::func_evt_t func_evt, // event pulses
    input wire logic [15:0] func_rdata, // function register read data
    output logic [15:0] reg_rdata, // read data, registered
    output logic reg_rvalid, // read data valid, one-cycle pulse
    output logic func_sel, // request targets a function register
    output logic [2:0] device_number_field, // bus device number
    output logic function_one_enable, // function runs (enabled, not shut, no device reset)
    output logic shutdown_mode, // shutdown selected
    output logic reduced_power_select, // low-power mode selected
    output logic device_reset_active, // device reset in progress
    output logic scan_tick // conversion pacing pulse
);

    // ==============================================================
    // Elaboration checks and local sizes
    // ==============================================================
    localparam int SCAN_W = $clog2(sensor_status_pkg::LOWP_SLOWDOWN
        * SCAN_DIV + 1);
    localparam int RST_W = $clog2(sensor_status_pkg::RST_OP_CYCLES + 1);

    if (SCAN_DIV < 1) begin : g_bad_div
        $error("SCAN_DIV must be at least one");
    end

    // ==============================================================
    // Address-select pin synchroniser
    // ==============================================================
    logic sel_meta_ff;
    logic sel_sync_ff;

    always_ff @(posedge sys_clk) begin
        sel_meta_ff <= addr_select_pin;
        sel_sync_ff <= sel_meta_ff;
    end

    assign device_number_field = sel_sync_ff ?
        sensor_status_pkg::DEVNUM_PIN_HIGH :
        sensor_status_pkg::DEVNUM_PIN_LOW;

    // ==============================================================
    // Request decode
    // ==============================================================
    logic [7:0] status_ff;
    logic [15:0] control_ff;
    logic [RST_W-1:0] rst_cnt_ff;
    logic rst_done;
    logic dev_rst;
    logic hit_status;
    logic hit_control;
    logic hit_readout;
    logic rd_status;
    logic rd_readout;
    logic wr_control;
    logic [15:0] wmask;

    assign hit_status = reg_req.addr == sensor_status_pkg::ADDR_STATUS;
    assign hit_control = reg_req.addr == sensor_status_pkg::ADDR_CONTROL;
    assign hit_readout = reg_req.addr == sensor_status_pkg::ADDR_READOUT;
    assign func_sel = reg_req.addr >= sensor_status_pkg::ADDR_FUNC_BASE;
    assign rd_status = reg_req.rd && hit_status && !device_reset_active;
    assign rd_readout = reg_req.rd && hit_readout && !device_reset_active;
    // A write arriving mid-reset is dropped: the reset is about to wipe it.
    assign wr_control = reg_req.wr && hit_control && !device_reset_active;
    assign wmask = reg_req.bcast ? sensor_status_pkg::BCAST_WMASK :
        sensor_status_pkg::CTRL_WMASK;

    // ==============================================================
    // Device reset sequencing
    // ==============================================================
    assign device_reset_active = control_ff[sensor_status_pkg::CT_RESET_BIT];
    assign rst_done = device_reset_active &&
        rst_cnt_ff == RST_W'(sensor_status_pkg::RST_OP_CYCLES - 1);
    // Power-up reset and the self-timed register reset share one path.
    assign dev_rst = srst || rst_done;

    always_ff @(posedge sys_clk) begin
        if (dev_rst || !device_reset_active) begin
            rst_cnt_ff <= '0;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + RST_W'(1);
        end
    end

    // ==============================================================
    // Control register
    // ==============================================================
    logic [15:0] nxt_control;

    assign nxt_control = wr_control ?
        (control_ff & ~wmask) | (reg_req.wdata & wmask) : control_ff;

    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            control_ff <= sensor_status_pkg::CONTROL_RST;
        end else begin
            control_ff <= nxt_control;
        end
    end

    assign shutdown_mode = control_ff[sensor_status_pkg::CT_SHUT_BIT];
    assign reduced_power_select = control_ff[sensor_status_pkg::CT_LOWP_BIT];
    assign function_one_enable = control_ff[sensor_status_pkg::CT_EN_BIT] &&
        !shutdown_mode && !device_reset_active;

    // ==============================================================
    // Status register
    // ==============================================================
    logic [7:0] nxt_status;
    logic evt_set;
    logic err_set;
    logic overrun;

    // An unread result being overwritten counts as a function error.
    assign overrun = func_evt.result_stored &&
        status_ff[sensor_status_pkg::ST_EVT_BIT] && !rd_readout;
    assign evt_set = func_evt.result_stored && !device_reset_active;
    assign err_set = (func_evt.error || overrun) && !device_reset_active;

    // Status writes are not decoded at all, so the flags stay put.
    always_comb begin
        nxt_status = status_ff;
        // Set beats a clearing read of the readout in the same cycle.
        nxt_status[sensor_status_pkg::ST_EVT_BIT] = evt_set ||
            (status_ff[sensor_status_pkg::ST_EVT_BIT] && !rd_readout);
        nxt_status[sensor_status_pkg::ST_ERR_BIT] = err_set ||
            (status_ff[sensor_status_pkg::ST_ERR_BIT] && !rd_readout);
        nxt_status[sensor_status_pkg::ST_NACK_BIT] = func_evt.nack ||
            (status_ff[sensor_status_pkg::ST_NACK_BIT] && !rd_status);
        nxt_status[3:1] = 3'h0;
        nxt_status[6:5] = 2'h0;
    end

    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            status_ff <= sensor_status_pkg::STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ==============================================================
    // Read path
    // ==============================================================
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        if (func_sel) begin
            rd_mux = func_rdata;
        end else if (hit_status) begin
            rd_mux = {8'h00, status_ff};
        end else if (hit_control) begin
            rd_mux = control_ff;
        end else if (reg_req.addr == sensor_status_pkg::ADDR_DEV_NUM) begin
            rd_mux = {13'h0000, device_number_field};
        end else if (reg_req.addr == sensor_status_pkg::ADDR_CAPS) begin
            rd_mux = {12'h000, sensor_status_pkg::FUNC_TYPE_TEMP};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    // ==============================================================
    // Conversion pacing
    // ==============================================================
    // Low-power mode stretches the period fourfold; shutdown stops it.
    logic [SCAN_W-1:0] scan_cnt_ff;
    logic [SCAN_W-1:0] scan_limit;

    assign scan_limit = reduced_power_select ?
        SCAN_W'(sensor_status_pkg::LOWP_SLOWDOWN * SCAN_DIV - 1) :
        SCAN_W'(SCAN_DIV - 1);

    always_ff @(posedge sys_clk) begin
        if (dev_rst || !function_one_enable) begin
            scan_cnt_ff <= '0;
            scan_tick <= 1'b0;
        end else if (scan_cnt_ff >= scan_limit) begin
            scan_cnt_ff <= '0;
            scan_tick <= 1'b1;
        end else begin
            scan_cnt_ff <= scan_cnt_ff + SCAN_W'(1);
            scan_tick <= 1'b0;
        end
    end

    // ==============================================================
    // Checks
    // ==============================================================
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence s_reset_write;
        wr_control && reg_req.wdata[sensor_status_pkg::CT_RESET_BIT];
    endsequence

    sequence s_reset_run;
        device_reset_active [*4] ##1 !device_reset_active;
    endsequence

    chk_reset_selfclear: assert property (
        s_reset_write |=> s_reset_run)
        else $error("reset bit did not self-clear after four cycles");

    chk_reset_defaults: assert property (
        rst_done |=> status_ff == 8'h00 && control_ff == 16'h0000)
        else $error("registers not at default after device reset");

    chk_bcast_mask: assert property (
        reg_req.wr && reg_req.bcast && hit_control && !device_reset_active
        |=> control_ff[15:2] == $past(control_ff[15:2]))
        else $error("broadcast write changed upper control bits");

    chk_status_reserved: assert property (
        status_ff[3:1] == 3'h0 && status_ff[6:5] == 2'h0)
        else $error("reserved status bits not zero");

    chk_ctrl_reserved: assert property (
        control_ff[3] == 1'b0 && control_ff[15:5] == 11'h000)
        else $error("unsupported control bits not zero");

    chk_nack_clear: assert property (
        rd_status && !func_evt.nack
        |=> !status_ff[sensor_status_pkg::ST_NACK_BIT])
        else $error("status read did not clear nack flag");

    chk_nack_set: assert property (
        func_evt.nack && !rst_done
        |=> status_ff[sensor_status_pkg::ST_NACK_BIT])
        else $error("nack did not set bus error flag");

    // Function results and errors are ignored while a device reset runs, so only check outside it.
    chk_overrun_err: assert property (
        overrun && !device_reset_active
        |=> status_ff[sensor_status_pkg::ST_ERR_BIT] &&
            status_ff[sensor_status_pkg::ST_EVT_BIT])
        else $error("overrun did not set function error flag");

    chk_readout_clear: assert property (
        rd_readout && !func_evt.result_stored && !func_evt.error
        |=> !status_ff[sensor_status_pkg::ST_EVT_BIT] &&
            !status_ff[sensor_status_pkg::ST_ERR_BIT])
        else $error("readout read did not clear function flags");

    chk_shutdown_halt: assert property (
        shutdown_mode |-> !function_one_enable ##1 !scan_tick)
        else $error("function ran during shutdown");

    // The pin reaches the device number two edges after it is sampled.
    chk_devnum_follow: assert property (
        device_number_field == ($past(addr_select_pin, 2) ? 3'h7 : 3'h1))
        else $error("device number did not follow select pin");

endmodule

// >>> dv/bus_master_model.sv
// Bus master seen as decoded one-cycle register requests.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/100ps

module bus_master_model (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic reg_rvalid, // read data valid pulse
    input wire logic [15:0] reg_rdata, // registered read data
    output sensor_status_pkg::reg_req_t reg_req // register request
);
    // ==============================================================
    // Request tasks
    // ==============================================================
    initial begin
        reg_req = '0;
    end

    // Idle cycles invert address and data so a stale value never matches.
    task automatic release_bus();
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.bcast = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d,
            input logic bc);
        @(posedge sys_clk);
        #1;
        reg_req.wr = 1'b1;
        reg_req.bcast = bc;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(posedge sys_clk);
        #1;
        release_bus();
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        #1;
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(posedge sys_clk);
        #1;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hDEAD;
        release_bus();
    endtask
endmodule

// >>> dv/sensor_device_status_control_tb_top.sv
// Self-checking bench for the device status and control register bank.
// Assumes bus_master_model drives the register requests.
`timescale 1ns/100ps

module sensor_device_status_control_tb_top;
    logic sys_clk, srst, addr_select_pin, func_sel, reg_rvalid, scan_tick;
    logic shutdown_mode, reduced_power_select, device_reset_active;
    logic function_one_enable;
    logic [15:0] func_rdata, reg_rdata;
    logic [2:0] device_number_field;
    sensor_status_pkg::reg_req_t reg_req;
    sensor_status_pkg::func_evt_t func_evt;
    int n_fail, checked, n, m;

    sensor_device_status_control #(.SCAN_DIV(4)) uut (
        .sys_clk(sys_clk), .srst(srst), .addr_select_pin(addr_select_pin),
        .reg_req(reg_req), .func_evt(func_evt), .func_rdata(func_rdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .func_sel(func_sel), .device_number_field(device_number_field),
        .function_one_enable(function_one_enable),
        .shutdown_mode(shutdown_mode),
        .reduced_power_select(reduced_power_select),
        .device_reset_active(device_reset_active), .scan_tick(scan_tick));

    bus_master_model master (.sys_clk(sys_clk), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata), .reg_req(reg_req));

    // ==============================================================
    // Shared tasks
    // ==============================================================
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] d;
        master.rd(a, d);
        chk(d, exp);
    endtask

    task automatic pulse(input sensor_status_pkg::func_evt_t v);
        @(posedge sys_clk);
        #1;
        func_evt = v;
        @(posedge sys_clk);
        #1;
        func_evt = '0;
    endtask

    task automatic ticks(output int cnt);
        cnt = 0;
        repeat (80) begin
            @(posedge sys_clk);
            #1;
            if (scan_tick === 1'b1) cnt++;
        end
    endtask

    task automatic test_done();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==============================================================
    // Scenarios
    // ==============================================================
    task automatic t_reset();
        chk({15'h0000, func_sel}, 16'h0000);
        rdc(6'h04, 16'h0000);
        rdc(6'h05, 16'h0000);
        rdc(6'h03, 16'h0001);
        // The idle bus now shows address 0x3C, inside the function range.
        chk({15'h0000, func_sel}, 16'h0001);
        chk({13'h0000, device_number_field}, 16'h0001);
        chk({15'h0000, function_one_enable}, 16'h0000);
    endtask

    task automatic t_nack();
        pulse(3'h1);
        master.wr(6'h04, 16'h0000, 1'b0);
        rdc(6'h04, 16'h0080);
        rdc(6'h04, 16'h0000);
    endtask

    task automatic t_func();
        func_rdata = 16'hA5C3;
        pulse(3'h4);
        rdc(6'h04, 16'h0001);
        pulse(3'h4);
        rdc(6'h04, 16'h0011);
        rdc(sensor_status_pkg::ADDR_READOUT, 16'hA5C3);
        rdc(6'h04, 16'h0000);
        pulse(3'h2);
        rdc(6'h04, 16'h0010);
        rdc(sensor_status_pkg::ADDR_READOUT, 16'hA5C3);
        rdc(6'h04, 16'h0000);
    endtask

    task automatic t_ctrl();
        master.wr(6'h05, 16'hFFFE, 1'b0);
        rdc(6'h05, 16'h0016);
        chk({15'h0000, shutdown_mode}, 16'h0001);
        chk({15'h0000, reduced_power_select}, 16'h0001);
        ticks(n);
        chk({15'h0000, function_one_enable}, 16'h0000);
        chk(16'(n), 16'h0000);
        master.wr(6'h05, 16'h0010, 1'b0);
        chk({15'h0000, function_one_enable}, 16'h0001);
        ticks(n);
        master.wr(6'h05, 16'h0014, 1'b0);
        ticks(m);
        chk({15'h0000, n >= 19 && n <= 21}, 16'h0001);
        chk({15'h0000, m >= 4 && m <= 6}, 16'h0001);
    endtask

    task automatic t_bcast();
        master.wr(6'h05, 16'h0010, 1'b0);
        master.wr(6'h05, 16'hFFFE, 1'b1);
        rdc(6'h05, 16'h0012);
        pulse(3'h1);
        master.wr(6'h05, 16'h0001, 1'b1);
        n = 0;
        while (device_reset_active === 1'b1 && n < 20) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk(16'(n), 16'h0004);
        rdc(6'h05, 16'h0000);
        rdc(6'h04, 16'h0000);
        chk({15'h0000, function_one_enable}, 16'h0000);
    endtask

    task automatic t_pin();
        addr_select_pin = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({13'h0000, device_number_field}, 16'h0007);
        addr_select_pin = 1'b0;
    endtask

    // ==============================================================
    // Clock, sequence and watchdog
    // ==============================================================
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        n_fail = 0;
        checked = 0;
        srst = 1'b1;
        addr_select_pin = 1'b0;
        func_evt = '0;
        func_rdata = 16'h0000;
        repeat (3) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        // No device reset is issued before first use.
        t_reset();
        t_nack();
        t_func();
        t_ctrl();
        t_bcast();
        t_pin();
        test_done();
    end

    // The sequence needs about 300 cycles; this leaves ample margin.
    initial begin
        #20000;
        n_fail++;
        test_done();
    end
endmodule
